// >>> verilog/pdrm_params.svh
// Constants for the dual register macrocell array: sizes, register map, reset values
`ifndef PDRM_PARAMS_SVH
`define PDRM_PARAMS_SVH

// ==========================================================
// Array sizes
`define PDRM_NCELL        10
`define PDRM_NREG         20

// ==========================================================
// Register byte offsets
`define PDRM_OFF_TYPE     8'h00
`define PDRM_OFF_CLKSEL   8'h04
`define PDRM_OFF_POL      8'h08
`define PDRM_OFF_SECURE   8'h0C
`define PDRM_OFF_STATE    8'h10
`define PDRM_OFF_PIN      8'h14

// ==========================================================
// Reset values and masks
`define PDRM_RST_TYPE     20'h0_0000
`define PDRM_RST_CLKSEL   20'h0_0000
`define PDRM_RST_POL      10'h000
`define PDRM_MASK_REG     32'h000F_FFFF
`define PDRM_MASK_CELL    32'h0000_03FF
`define PDRM_MASK_SEC     32'h0000_0001
`define PDRM_SEL_LOW      20'h0_03FF
`define PDRM_SEL_HIGH     20'hF_FC00

// ==========================================================
// AXI responses
`define PDRM_RESP_OKAY    2'h0
`define PDRM_RESP_SLVERR  2'h2

`endif

// >>> verilog/pdrm_pkg.sv
// Types shared by the dual register macrocell array
package pdrm_pkg;

  // ==========================================================
  // Per-register terms coming from the programmable array
  typedef struct packed {
    logic [19:0] sum;   // Data sum term
    logic [19:0] rst;   // Asynchronous reset product term
    logic [19:0] clk;   // Clock product term
  } pdrm_terms_t;

endpackage

// >>> verilog/pdrm_macrocell.sv
// Twenty-register dual macrocell array with AXI4-Lite configuration access
`timescale 1ns/1ps
`include "pdrm_params.svh"

// Function
// [R01] Per-register D or T type select
// [R02] Per-register clock: term or pin
// [R03] Two registers per cell, twenty total
// [R04] Own sum, reset, clock term each
// [R05] Pins have separate input path
// [R06] All twenty registers feed back independently
// [R07] Each pin enabled by own term
// [R08] Shared synchronous preset sets on clock
// [R09] Driver must raise clocks during preset
// [R10] Own immediate reset per register
// [R11] Reset clears master and slave stage
// [R12] Secured device reads config as ones
// [R13] Program security bit last
// [R14] Power-up clears every register to zero
// [R15] Force-load pins into register 0/1
// [R16] D loads sum; T toggles on sum
// [R17] Reset beats preset and data loading
module pdrm_macrocell (
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire pdrm_pkg::pdrm_terms_t TERMS,
  input  wire logic               CLK_PIN,
  input  wire logic               PRESET_TERM,
  input  wire logic               FORCE_MODE,
  input  wire logic               FORCE_SEL,
  input  wire logic [9:0]         OE_TERM,
  input  wire logic [9:0]         IO_IN,
  output logic      [9:0]         IO_OUT,
  output logic      [9:0]         IO_OE,
  output logic      [19:0]        REG_FB,
  output logic      [9:0]         PIN_FB,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic      [1:0]         S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic      [31:0]        S_AXI_RDATA,
  output logic      [1:0]         S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY
);

  // ==========================================================
  // Configuration and state
  logic [19:0] type_ff;     // 1 = toggle type
  logic [19:0] clksel_ff;   // 1 = dedicated pin clock
  logic [9:0]  pol_ff;      // 1 = invert pin output
  logic        secure_ff;
  logic [19:0] state_ff;    // Slave stage of each register
  logic [19:0] clk_prev_ff; // Master stage: last sampled clock level
  logic [9:0]  pin_ff;
  logic [19:0] clk_now;
  logic [19:0] clk_edge;
  logic [19:0] force_mask;
  logic [19:0] do_pre;
  logic [19:0] do_frc;
  logic [19:0] do_data;
  logic [19:0] data_val;
  logic [19:0] nxt_state;

  // Masks a configuration word so a secured device hides it
  function automatic logic [31:0] cfg_view(input logic [31:0] val, input logic [31:0] mask, input logic sec);
    cfg_view = sec ? mask : (val & mask);
  endfunction

  // Clock source and rising edge per register
  assign clk_now  = (clksel_ff & {20{CLK_PIN}}) | (~clksel_ff & TERMS.clk); // [R02]
  assign clk_edge = clk_now & ~clk_prev_ff;

  // Next-state selection; preset outranks force-load, force-load outranks data
  assign force_mask = FORCE_SEL ? `PDRM_SEL_HIGH : `PDRM_SEL_LOW; // [R15]
  assign do_pre     = clk_edge & {20{PRESET_TERM}}; // [R08]
  assign do_frc     = clk_edge & ~do_pre & {20{FORCE_MODE}} & force_mask; // [R15]
  assign do_data    = clk_edge & ~{20{PRESET_TERM}} & ~{20{FORCE_MODE}};
  assign data_val   = (type_ff & (state_ff ^ TERMS.sum)) | (~type_ff & TERMS.sum); // [R01] [R16]
  assign nxt_state  = ~TERMS.rst & (do_pre | (do_frc & {IO_IN, IO_IN}) | (do_data & data_val) // [R17] [R04]
                      | (state_ff & ~(do_pre | do_frc | do_data)));

  // Register array; power-up reset gives all zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_ff <= 20'h0_0000; // [R14]
    end else begin
      state_ff <= nxt_state; // [R03] [R10]
    end
  end

  // Master stage; forced high under reset so a held clock cannot fire on release
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      clk_prev_ff <= 20'hF_FFFF;
    end else begin
      clk_prev_ff <= clk_now | TERMS.rst; // [R11]
    end
  end

  // Feedback masked at once by a reset term, not a cycle later
  assign REG_FB = state_ff & ~TERMS.rst; // [R06] [R10]

  // Pin side: register 0 of each cell drives the pin through its polarity
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_ff <= 10'h000;
    end else begin
      pin_ff <= IO_IN; // [R05]
    end
  end
  assign PIN_FB = pin_ff;
  assign IO_OUT = REG_FB[9:0] ^ pol_ff; // [R14]
  assign IO_OE  = OE_TERM; // [R07]

  // ==========================================================
  // AXI4-Lite write path; address and data taken in either order
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        wr_go;
  logic        wr_hit;

  assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
  assign S_AXI_WREADY  = ~w_got_ff & ~bvalid_ff;
  assign wr_go         = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_hit        = (awaddr_ff == `PDRM_OFF_TYPE) | (awaddr_ff == `PDRM_OFF_CLKSEL)
                         | (awaddr_ff == `PDRM_OFF_POL) | (awaddr_ff == `PDRM_OFF_SECURE);
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;

  // Capture of address and data halves
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_got_ff <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
      end else if (wr_go) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Write response; held until the master takes it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `PDRM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `PDRM_RESP_OKAY : `PDRM_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Configuration writes; only the low byte lanes that hold data matter
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      type_ff   <= `PDRM_RST_TYPE;
      clksel_ff <= `PDRM_RST_CLKSEL;
      pol_ff    <= `PDRM_RST_POL;
      secure_ff <= 1'b0;
    end else if (wr_go) begin
      case (awaddr_ff)
        `PDRM_OFF_TYPE:   type_ff   <= wdata_ff[19:0]; // [R01]
        `PDRM_OFF_CLKSEL: clksel_ff <= wdata_ff[19:0]; // [R02]
        `PDRM_OFF_POL:    pol_ff    <= wdata_ff[9:0];
        // Like a fuse: once set it stays until reset
        `PDRM_OFF_SECURE: secure_ff <= secure_ff | wdata_ff[0]; // [R12]
        default:          type_ff   <= type_ff;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read path; one cycle from address to data
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  // Read data; configuration reads as all ones once secured
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `PDRM_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `PDRM_RESP_OKAY;
      case (S_AXI_ARADDR)
        `PDRM_OFF_TYPE:   rdata_ff <= cfg_view({12'h000, type_ff}, `PDRM_MASK_REG, secure_ff); // [R12]
        `PDRM_OFF_CLKSEL: rdata_ff <= cfg_view({12'h000, clksel_ff}, `PDRM_MASK_REG, secure_ff); // [R12]
        `PDRM_OFF_POL:    rdata_ff <= cfg_view({22'h00_0000, pol_ff}, `PDRM_MASK_CELL, secure_ff); // [R12]
        `PDRM_OFF_SECURE: rdata_ff <= {31'h0000_0000, secure_ff};
        `PDRM_OFF_STATE:  rdata_ff <= {12'h000, REG_FB};
        `PDRM_OFF_PIN:    rdata_ff <= {22'h00_0000, pin_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `PDRM_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_reset_clears_reg: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    (TERMS.rst != 20'h0_0000) |=> ((state_ff & $past(TERMS.rst)) == 20'h0_0000))
    else $error("reset term did not clear register");

  a_fb_masked_now: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
    ((REG_FB & TERMS.rst) == 20'h0_0000))
    else $error("feedback not cleared while reset term high");

  a_preset_sets_reg: assert property (@(posedge SYS_CLK) disable iff (RST) // [R08]
    (PRESET_TERM && (clk_edge & ~TERMS.rst) != 20'h0_0000)
    |=> ((state_ff & $past(clk_edge & ~TERMS.rst)) == $past(clk_edge & ~TERMS.rst)))
    else $error("synchronous preset did not set register");

  a_dtype_loads_sum: assert property (@(posedge SYS_CLK) disable iff (RST) // [R16]
    (!PRESET_TERM && !FORCE_MODE && clk_edge[0] && !type_ff[0] && !TERMS.rst[0])
    |=> (state_ff[0] == $past(TERMS.sum[0])))
    else $error("D register did not load sum term");

  a_ttype_toggles: assert property (@(posedge SYS_CLK) disable iff (RST) // [R16]
    (!PRESET_TERM && !FORCE_MODE && clk_edge[1] && type_ff[1] && TERMS.sum[1] && !TERMS.rst[1])
    |=> (state_ff[1] != $past(state_ff[1])))
    else $error("T register did not toggle");

  a_hold_no_edge: assert property (@(posedge SYS_CLK) disable iff (RST) // [R02]
    (!clk_edge[5] && !TERMS.rst[5]) |=> $stable(state_ff[5]))
    else $error("register changed without a clock edge");

  a_force_load_pin: assert property (@(posedge SYS_CLK) disable iff (RST) // [R15]
    (FORCE_MODE && !PRESET_TERM && FORCE_SEL && clk_edge[12] && !TERMS.rst[12])
    |=> (state_ff[12] == $past(IO_IN[2])))
    else $error("force-load did not take pin level");

  a_secure_mask_rd: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    (secure_ff && S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `PDRM_OFF_TYPE)
    |=> (S_AXI_RVALID && S_AXI_RDATA == `PDRM_MASK_REG))
    else $error("secured read exposed configuration");

  a_powerup_zero: assert property (@(posedge SYS_CLK) // [R14]
    RST |=> (state_ff == 20'h0_0000))
    else $error("registers not zero after reset");

  // ==========================================================
  // Checks on reset stages, pin path, force bank and the fuse
  // A stale master level would clock a register the cycle its reset lets go
  a_master_cleared: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    (TERMS.rst != 20'h0_0000) |=> ((clk_edge & $past(TERMS.rst)) == 20'h0_0000))
    else $error("edge seen right after reset term");

  a_pin_fb_delay: assert property (@(posedge SYS_CLK) disable iff (RST) // [R05]
    1'b1 |=> (PIN_FB == $past(IO_IN)))
    else $error("pin input path not one cycle");

  a_reset_beats_pre: assert property (@(posedge SYS_CLK) disable iff (RST) // [R17]
    (PRESET_TERM && TERMS.rst[5]) |=> !state_ff[5])
    else $error("preset overrode reset term");

  // Unselected bank must hold, so a full preload takes two passes
  a_unsel_bank_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // [R15]
    (FORCE_MODE && !PRESET_TERM && !FORCE_SEL && clk_edge[15] && !TERMS.rst[15])
    |=> $stable(state_ff[15]))
    else $error("force-load touched unselected register");

  a_secure_sticky: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
    secure_ff |=> secure_ff)
    else $error("security bit cleared without reset");

endmodule // pdrm_macrocell

// >>> verif/pdrm_user_logic.sv
// Behavioural user logic that drives the array terms and clock pin
`timescale 1ns/1ps
module pdrm_user_logic (
  input  wire logic             sys_clk,
  input  wire logic [19:0]      sum_req,
  input  wire logic [19:0]      rst_req,
  input  wire logic [19:0]      clk_req,
  input  wire logic             pin_req,
  input  wire logic             preset_req,
  output pdrm_pkg::pdrm_terms_t terms,
  output logic                  clk_pin,
  output logic                  preset_term
);
  // ========================
  // Term registers
  pdrm_pkg::pdrm_terms_t terms_ff;
  logic                  pin_ff;
  logic                  preset_ff;
  // All terms move together, so a preset and its clocks line up
  always_ff @(posedge sys_clk) begin
    terms_ff.sum <= sum_req;
    terms_ff.rst <= rst_req;
    // Preset is lost unless every clock goes high with it
    terms_ff.clk <= preset_req ? 20'hF_FFFF : clk_req;
    pin_ff       <= pin_req | preset_req;
    preset_ff    <= preset_req;
  end
  assign terms       = terms_ff;
  assign clk_pin     = pin_ff;
  assign preset_term = preset_ff;
endmodule // pdrm_user_logic

// >>> verif/tb_top.sv
// Self-checking bench for the dual register macrocell array
`timescale 1ns/1ps
module tb_top;
  logic                  sys_clk, rst, clk_pin, pin_req, preset_req, preset_term, force_mode, force_sel;
  logic [19:0]           sum_req, rst_req, clk_req, reg_fb;
  logic [9:0]            oe_term, io_in, io_out, io_oe, pin_fb;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  pdrm_pkg::pdrm_terms_t terms;
  int                    err_total, n_compared;

  // Free-running system clock
  always #2 sys_clk = ~sys_clk;

  pdrm_user_logic pdrm_user_logic_inst (.sys_clk(sys_clk), .sum_req(sum_req), .rst_req(rst_req),
    .clk_req(clk_req), .pin_req(pin_req), .preset_req(preset_req), .terms(terms),
    .clk_pin(clk_pin), .preset_term(preset_term));
  pdrm_macrocell pdrm_macrocell_inst (.SYS_CLK(sys_clk), .RST(rst), .TERMS(terms), .CLK_PIN(clk_pin),
    .PRESET_TERM(preset_term), .FORCE_MODE(force_mode), .FORCE_SEL(force_sel), .OE_TERM(oe_term),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .REG_FB(reg_fb), .PIN_FB(pin_fb),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  // ========================
  // Checking and closing
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask

  // ========================
  // Bus access: one write or one read, response compared, and data on reads
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int   n;
    logic aw, w;
    @(posedge sys_clk);
    n = 0;
    aw = wr;
    w = wr;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    // Each half is released at the edge that takes it
    do begin
      @(posedge sys_clk);
      n++;
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!(wr ? bvalid : rvalid) && n < 64);
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 64) begin
      err_total++;
      report_and_stop;
    end else begin
      chk("resp", {30'h0, r}, {30'h0, wr ? bresp : rresp});
      if (!wr) begin
        chk("rdata", d, rdata);
      end
    end
  endtask

  // Clock pulse through the user logic, then settle
  task pulse(input logic [19:0] m, input logic p, input logic pre);
    @(posedge sys_clk);
    clk_req <= m;
    pin_req <= p;
    preset_req <= pre;
    repeat (2) @(posedge sys_clk);
    clk_req <= 20'h0_0000;
    pin_req <= 1'b0;
    preset_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ========================
  // Main sequence
  initial begin
    sys_clk = 0;
    {rst, pin_req, preset_req, force_mode, force_sel} = 5'h10;
    {sum_req, rst_req, clk_req, oe_term, io_in} = 80'h0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = 53'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    bus(0, 8'h10, 32'h0000_0000, 2'h0);
    bus(0, 8'h00, 32'h0000_0000, 2'h0);
    chk("io_out", 32'h0000_0000, {22'h0, io_out});
    $display("test reset done");
    bus(1, 8'h00, 32'h0000_0002, 2'h0);
    bus(1, 8'h04, 32'h0000_0004, 2'h0);
    bus(1, 8'h08, 32'h0000_0001, 2'h0);
    bus(0, 8'h04, 32'h0000_0004, 2'h0);
    bus(1, 8'h18, 32'h0000_00FF, 2'h2);
    bus(0, 8'h18, 32'h0000_0000, 2'h2);
    $display("test config done");
    // Reg 0 D, reg 1 T, reg 2 on the clock pin
    sum_req <= 20'h0_0007;
    pulse(20'h0_0003, 1'b0, 1'b0);
    chk("reg_fb", 32'h0000_0003, {12'h0, reg_fb});
    chk("io_out", 32'h0000_0002, {22'h0, io_out});
    pulse(20'h0_0003, 1'b0, 1'b0);
    chk("reg_fb", 32'h0000_0001, {12'h0, reg_fb});
    pulse(20'h0_0004, 1'b0, 1'b0);
    chk("reg_fb", 32'h0000_0001, {12'h0, reg_fb});
    pulse(20'h0_0000, 1'b1, 1'b0);
    chk("reg_fb", 32'h0000_0005, {12'h0, reg_fb});
    bus(0, 8'h10, 32'h0000_0005, 2'h0);
    $display("test logic done");
    io_in <= 10'h155;
    oe_term <= 10'h0F0;
    repeat (2) @(posedge sys_clk);
    chk("pin_fb", 32'h0000_0155, {22'h0, pin_fb});
    chk("io_oe", 32'h0000_00F0, {22'h0, io_oe});
    bus(0, 8'h14, 32'h0000_0155, 2'h0);
    $display("test pins done");
    pulse(20'h0_0000, 1'b0, 1'b1);
    chk("reg_fb", 32'h000F_FFFF, {12'h0, reg_fb});
    rst_req <= 20'h0_0020;
    repeat (2) @(posedge sys_clk);
    chk("reg_fb", 32'h000F_FFDF, {12'h0, reg_fb});
    pulse(20'h0_0000, 1'b0, 1'b1);
    chk("reg_fb", 32'h000F_FFDF, {12'h0, reg_fb});
    rst_req <= 20'h0_0000;
    repeat (3) @(posedge sys_clk);
    chk("reg_fb", 32'h000F_FFDF, {12'h0, reg_fb});
    $display("test preset done");
    force_mode <= 1'b1;
    force_sel <= 1'b1;
    io_in <= 10'h2A5;
    pulse(20'hF_FFFF, 1'b1, 1'b0);
    chk("reg_fb", 32'h000A_97DF, {12'h0, reg_fb});
    force_sel <= 1'b0;
    pulse(20'hF_FFFF, 1'b1, 1'b0);
    chk("reg_fb", 32'h000A_96A5, {12'h0, reg_fb});
    force_mode <= 1'b0;
    $display("test force done");
    // Security goes last since masking starts at once
    bus(1, 8'h0C, 32'h0000_0001, 2'h0);
    bus(0, 8'h0C, 32'h0000_0001, 2'h0);
    bus(0, 8'h00, 32'h000F_FFFF, 2'h0);
    bus(0, 8'h08, 32'h0000_03FF, 2'h0);
    $display("test security done");
    report_and_stop;
  end
endmodule // tb_top
